/* logic/cvap_char_video.sv */
// Behaviour
// - Glyph address: code bits high, scan low
// - Latch word, look up, load, shift out
// - Character cell is nine dots wide
// - Ninth dot repeats the first dot
// - Dot rate about 14.43098 MHz
// - Controller makes blank and sync signals
// - Hold bit: request bus outside sync
// - Grant steers RAM address to controller
// - Hold bit low suppresses bus request
// - Vertical sync divided by 32 blinks
// - Word bit 7 captured as flag
// - Global blank bit blanks all video
// - Reverse bit reverses flagged characters
// - Underline bit and gates kept inactive
// - Selective inverter on dot video
// - Blank during vertical sync, horizontal blank
// - Flag with blink bit blanks blinking
// - Cursor scan 9 reversed while blinking
// - Reverse when flag and reverse selected
// - Underline input of blank gate inactive
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module cvap_char_video (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Processor bus arbitration
    output logic bus_request_n,
    input wire logic bus_grant_n,
    // Display RAM
    input wire logic [cvap_pkg::RAM_AW-1:0] cpu_ram_addr,
    output logic [cvap_pkg::RAM_AW-1:0] ram_addr,
    input wire logic [7:0] ram_rdata,
    // Video outputs
    output logic video_out,
    output logic hsync_out,
    output logic vsync_out,
    output logic csync_out,
    output logic blink_out
);

    // ----------------------------------------
    // Dot and character timing
    // ----------------------------------------
    logic [cvap_pkg::NCO_W-1:0] nco_r;
    logic [cvap_pkg::NCO_W:0] nco_sum;
    logic dot_tick_r;
    logic [3:0] dot_cnt_r;
    logic char_tick;

    // Fractional divider gives the dot rate without a second clock domain
    assign nco_sum = {1'b0, nco_r} + {1'b0, cvap_pkg::NCO_INC};

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            nco_r <= '0;
            dot_tick_r <= 1'b0;
        end else begin
            nco_r <= nco_sum[cvap_pkg::NCO_W-1:0];
            dot_tick_r <= nco_sum[cvap_pkg::NCO_W];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dot_cnt_r <= 4'h0;
        end else if (dot_tick_r) begin
            dot_cnt_r <= (dot_cnt_r == cvap_pkg::CHAR_LAST) ? 4'h0 : dot_cnt_r + 4'h1;
        end
    end

    assign char_tick = dot_tick_r && (dot_cnt_r == cvap_pkg::CHAR_LAST);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] ctrl_r;
    logic [cvap_pkg::GLYPH_AW-1:0] glyph_waddr_r;
    logic [cvap_pkg::COL_W-1:0] cursor_col_r;
    logic [cvap_pkg::ROW_W-1:0] cursor_row_r;
    logic [cvap_pkg::BLINK_W-1:0] blink_cnt_r;
    logic glyph_we;
    logic bus_hold;
    logic blank_all;
    logic rev_en;
    logic blink_en;
    logic underline_en;

    assign glyph_we = reg_wr && (reg_addr == cvap_pkg::REG_GLYPH_DATA);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= cvap_pkg::VIDEO_CTRL_RST;
        end else if (reg_wr && reg_addr == cvap_pkg::REG_VIDEO_CTRL) begin
            ctrl_r <= reg_wdata;
        end
    end

    // Glyph address auto-increments so a whole pattern loads in a burst
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            glyph_waddr_r <= '0;
        end else if (reg_wr && reg_addr == cvap_pkg::REG_GLYPH_ADDR) begin
            glyph_waddr_r <= {reg_wdata[cvap_pkg::CODE_W-1:0], cvap_pkg::SCAN_W'(0)};
        end else if (glyph_we) begin
            glyph_waddr_r <= glyph_waddr_r + 11'h001;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cursor_col_r <= '0;
            cursor_row_r <= '0;
        end else if (reg_wr && reg_addr == cvap_pkg::REG_CURSOR) begin
            cursor_col_r <= reg_wdata[cvap_pkg::COL_W-1:0];
        end else if (reg_wr && reg_addr == cvap_pkg::REG_CURSOR + 8'h04) begin
            cursor_row_r <= reg_wdata[cvap_pkg::ROW_W-1:0];
        end
    end

    assign bus_hold = ctrl_r[cvap_pkg::CTRL_BUS_HOLD];
    assign blank_all = ctrl_r[cvap_pkg::CTRL_BLANK_ALL];
    assign rev_en = ctrl_r[cvap_pkg::CTRL_REVERSE];
    assign blink_en = ctrl_r[cvap_pkg::CTRL_BLINK];
    // Underline enhancement is stored but never reaches the gates
    assign underline_en = 1'b0;

    // Control latch is write-only and reads as zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                cvap_pkg::REG_STATUS: reg_rdata <= {~bus_grant_n, ~bus_request_n, 1'b0, blink_cnt_r};
                cvap_pkg::REG_GLYPH_ADDR: reg_rdata <= {1'b0, glyph_waddr_r[cvap_pkg::GLYPH_AW-1:cvap_pkg::SCAN_W]};
                cvap_pkg::REG_CURSOR: reg_rdata <= {1'b0, cursor_col_r};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ----------------------------------------
    // Timing controller
    // ----------------------------------------
    logic tc_hblank;
    logic tc_hsync;
    logic tc_vsync;
    logic tc_csync;
    logic tc_cursor;
    logic [cvap_pkg::SCAN_W-1:0] tc_scan;
    logic [cvap_pkg::RAM_AW-1:0] tc_addr;

    cvap_crt_timing_ctrl u_crt_timing_ctrl (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .char_tick(char_tick),
        .cursor_col(cursor_col_r),
        .cursor_row(cursor_row_r),
        .hblank(tc_hblank),
        .hsync(tc_hsync),
        .vsync(tc_vsync),
        .csync(tc_csync),
        .cursor_hit(tc_cursor),
        .scan(tc_scan),
        .ram_addr(tc_addr)
    );

    // ----------------------------------------
    // Bus arbitration and RAM address mux
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_request_n <= 1'b1;
        end else begin
            // Hold low drops the request: processor never suspended
            bus_request_n <= ~(bus_hold & ~tc_csync);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ram_addr <= '0;
        end else begin
            ram_addr <= bus_grant_n ? cpu_ram_addr : tc_addr;
        end
    end

    // ----------------------------------------
    // Blink divider
    // ----------------------------------------
    logic vsync_d_r;
    logic blink;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            vsync_d_r <= 1'b0;
            blink_cnt_r <= '0;
        end else begin
            vsync_d_r <= tc_vsync;
            if (tc_vsync && !vsync_d_r) begin
                blink_cnt_r <= blink_cnt_r + 5'h01;
            end
        end
    end

    assign blink = blink_cnt_r[cvap_pkg::BLINK_W-1];

    // ----------------------------------------
    // Character pipeline
    // ----------------------------------------
    logic [7:0] ram_word_r;
    logic [cvap_pkg::SCAN_W-1:0] scan_d1_r;
    logic [cvap_pkg::SCAN_W-1:0] scan_d2_r;
    logic [1:0] cursor_d_r;
    logic [1:0] hblank_d_r;
    logic [7:0] glyph_dots;
    logic [cvap_pkg::GLYPH_AW-1:0] glyph_addr;
    logic [7:0] dot_shifter_r;
    logic enhance_flag_r;

    assign glyph_addr = {ram_word_r[cvap_pkg::CODE_W-1:0], scan_d1_r};

    cvap_glyph_rom u_glyph_rom (
        .sys_clk(sys_clk),
        .wr_en(glyph_we),
        .wr_addr(glyph_waddr_r),
        .wr_data(reg_wdata),
        .rd_addr(glyph_addr),
        .rd_data(glyph_dots)
    );

    // Side signals travel two character stages, in step with the dots
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ram_word_r <= 8'h00;
            scan_d1_r <= '0;
            scan_d2_r <= '0;
            cursor_d_r <= 2'h0;
            hblank_d_r <= 2'h3;
        end else if (char_tick) begin
            ram_word_r <= ram_rdata;
            scan_d1_r <= tc_scan;
            scan_d2_r <= scan_d1_r;
            cursor_d_r <= {cursor_d_r[0], tc_cursor};
            hblank_d_r <= {hblank_d_r[0], tc_hblank};
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dot_shifter_r <= 8'h00;
        end else if (char_tick) begin
            dot_shifter_r <= glyph_dots;
        end else if (dot_tick_r) begin
            // Last output fed back so the ninth dot equals the first
            dot_shifter_r <= {dot_shifter_r[6:0], dot_shifter_r[7]};
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            enhance_flag_r <= 1'b0;
        end else if (char_tick) begin
            enhance_flag_r <= ram_word_r[7];
        end
    end

    // ----------------------------------------
    // Reverse, blank and output
    // ----------------------------------------
    logic dot_n;
    logic reverse_cond;
    logic sel_video;
    logic enhance_blank;
    logic blank_any;

    assign dot_n = ~dot_shifter_r[7];
    assign reverse_cond = (blink & cursor_d_r[1] & (scan_d2_r == cvap_pkg::CURSOR_SCAN))
        | (enhance_flag_r & rev_en)
        | (enhance_flag_r & underline_en);
    assign sel_video = dot_n ^ reverse_cond;
    assign enhance_blank = (enhance_flag_r & blink_en & blink) | underline_en;
    assign blank_any = tc_vsync | hblank_d_r[1] | blank_all | enhance_blank;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            video_out <= 1'b0;
            hsync_out <= 1'b0;
            vsync_out <= 1'b0;
            csync_out <= 1'b0;
            blink_out <= 1'b0;
        end else begin
            video_out <= ~sel_video & ~blank_any;
            hsync_out <= tc_hsync;
            vsync_out <= tc_vsync;
            csync_out <= tc_csync;
            blink_out <= blink;
        end
    end
endmodule // cvap_char_video

/* logic/cvap_crt_timing_ctrl.sv */
`timescale 1ns/1ps
module cvap_crt_timing_ctrl #(
    parameter int H_ACTIVE = cvap_pkg::H_ACTIVE,
    parameter int H_SYNC_START = cvap_pkg::H_SYNC_START,
    parameter int H_SYNC_END = cvap_pkg::H_SYNC_END,
    parameter int H_TOTAL = cvap_pkg::H_TOTAL,
    parameter int SCANS = cvap_pkg::SCANS_PER_ROW,
    parameter int V_ROWS = cvap_pkg::V_ACTIVE_ROWS,
    parameter int V_SYNC_START = cvap_pkg::V_SYNC_START,
    parameter int V_SYNC_END = cvap_pkg::V_SYNC_END,
    parameter int V_TOTAL = cvap_pkg::V_TOTAL
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Character rate
    input wire logic char_tick,
    // Cursor position
    input wire logic [cvap_pkg::COL_W-1:0] cursor_col,
    input wire logic [cvap_pkg::ROW_W-1:0] cursor_row,
    // Timing outputs
    output logic hblank,
    output logic hsync,
    output logic vsync,
    output logic csync,
    output logic cursor_hit,
    output logic [cvap_pkg::SCAN_W-1:0] scan,
    output logic [cvap_pkg::RAM_AW-1:0] ram_addr
);
    logic [7:0] hcnt_r;
    logic [8:0] line_r;
    logic [cvap_pkg::SCAN_W-1:0] scan_r;
    logic [cvap_pkg::ROW_W-1:0] row_r;
    logic hs;
    logic vs;
    logic hb;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hcnt_r <= 8'h00;
            line_r <= 9'h000;
            scan_r <= '0;
            row_r <= '0;
        end else if (char_tick) begin
            if (hcnt_r == 8'(H_TOTAL - 1)) begin
                hcnt_r <= 8'h00;
                if (line_r == 9'(V_TOTAL - 1)) begin
                    line_r <= 9'h000;
                    scan_r <= '0;
                    row_r <= '0;
                end else begin
                    line_r <= line_r + 9'h001;
                    if (scan_r == 4'(SCANS - 1)) begin
                        scan_r <= '0;
                        row_r <= row_r + 5'h01;
                    end else begin
                        scan_r <= scan_r + 4'h1;
                    end
                end
            end else begin
                hcnt_r <= hcnt_r + 8'h01;
            end
        end
    end

    assign hs = (hcnt_r >= 8'(H_SYNC_START)) && (hcnt_r < 8'(H_SYNC_END));
    assign vs = (line_r >= 9'(V_SYNC_START)) && (line_r < 9'(V_SYNC_END));
    assign hb = (hcnt_r >= 8'(H_ACTIVE)) || (line_r >= 9'(V_ROWS * SCANS));

    // Blanking and sync outputs, all registered
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hblank <= 1'b1;
            hsync <= 1'b0;
            vsync <= 1'b0;
            csync <= 1'b0;
            cursor_hit <= 1'b0;
            scan <= '0;
            ram_addr <= '0;
        end else begin
            hblank <= hb;
            hsync <= hs;
            vsync <= vs;
            csync <= hs ^ vs;
            cursor_hit <= (hcnt_r == {1'b0, cursor_col}) && (row_r == cursor_row);
            scan <= scan_r;
            ram_addr <= {row_r, hcnt_r[cvap_pkg::COL_W-1:0]};
        end
    end
endmodule // cvap_crt_timing_ctrl

/* logic/cvap_glyph_rom.sv */
`timescale 1ns/1ps
module cvap_glyph_rom #(
    parameter int AW = cvap_pkg::GLYPH_AW
) (
    // Clock
    input wire logic sys_clk,
    // Load port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Lookup
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    // No reset: pattern store is loaded by software after power-up
    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule // cvap_glyph_rom

/* logic/cvap_pkg.sv */
package cvap_pkg;

    // ----------------------------------------
    // Clocking
    // ----------------------------------------
    localparam longint SYS_CLK_HZ = 64'd250000000;
    localparam longint DOT_CLK_HZ = 64'd14430980;
    localparam int NCO_W = 32;
    localparam logic [31:0] NCO_INC = 32'((DOT_CLK_HZ << NCO_W) / SYS_CLK_HZ);
    localparam int CHAR_DOTS = 9;
    localparam logic [3:0] CHAR_LAST = 4'(CHAR_DOTS - 1);

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] REG_VIDEO_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_GLYPH_ADDR = 8'h08;
    localparam logic [7:0] REG_GLYPH_DATA = 8'h0C;
    localparam logic [7:0] REG_CURSOR = 8'h10;

    localparam logic [7:0] VIDEO_CTRL_RST = 8'h80;
    localparam int CTRL_BUS_HOLD = 7;
    localparam int CTRL_UNDERLINE = 4;
    localparam int CTRL_BLANK_ALL = 3;
    localparam int CTRL_REVERSE = 2;
    localparam int CTRL_BLINK = 1;

    // ----------------------------------------
    // Character and raster geometry
    // ----------------------------------------
    localparam int CODE_W = 7;
    localparam int SCAN_W = 4;
    localparam int GLYPH_AW = CODE_W + SCAN_W;
    localparam int COL_W = 7;
    localparam int ROW_W = 5;
    localparam int RAM_AW = COL_W + ROW_W;
    localparam logic [SCAN_W-1:0] CURSOR_SCAN = 4'h9;
    localparam int BLINK_W = 5;

    localparam int H_ACTIVE = 80;
    localparam int H_SYNC_START = 86;
    localparam int H_SYNC_END = 94;
    localparam int H_TOTAL = 102;
    localparam int SCANS_PER_ROW = 10;
    localparam int V_ACTIVE_ROWS = 24;
    localparam int V_SYNC_START = 250;
    localparam int V_SYNC_END = 253;
    localparam int V_TOTAL = 262;

endpackage

/* test/cvap_char_video_assertions.sv */
`timescale 1ns/1ps
module cvap_char_video_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Bus and RAM address
    input wire logic bus_request_n,
    input wire logic bus_grant_n,
    input wire logic [cvap_pkg::RAM_AW-1:0] cpu_ram_addr,
    input wire logic [cvap_pkg::RAM_AW-1:0] ram_addr,
    // Video
    input wire logic video_out,
    input wire logic hsync_out,
    input wire logic vsync_out,
    input wire logic csync_out
);
    // ----------------------------------------
    // Shadow of the write-only control latch
    // ----------------------------------------
    logic [7:0] ctrl_r;
    logic [9:0] blank_cnt_r;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= cvap_pkg::VIDEO_CTRL_RST;
        end else if (reg_wr && reg_addr == cvap_pkg::REG_VIDEO_CTRL) begin
            ctrl_r <= reg_wdata;
        end
    end

    // Long enough to cover the character pipeline before video must be dark
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            blank_cnt_r <= 10'h000;
        end else if (!ctrl_r[cvap_pkg::CTRL_BLANK_ALL]) begin
            blank_cnt_r <= 10'h000;
        end else if (blank_cnt_r != 10'h3FF) begin
            blank_cnt_r <= blank_cnt_r + 10'h001;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    property p_hold_off;
        !ctrl_r[7] && !$past(ctrl_r[7]) |-> bus_request_n;
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("request raised with hold bit low");

    property p_req_idle;
        ctrl_r[7] && $past(ctrl_r[7]) && csync_out && $past(csync_out) && $past(csync_out, 2) |-> bus_request_n;
    endproperty
    a_req_idle: assert property (p_req_idle) else $error("request held during sync");

    property p_req_busy;
        // Request lags the hold bit by one cycle and is still idle just after reset
        ctrl_r[7] && $past(ctrl_r[7]) && $past(reset_n, 2)
            && !csync_out && !$past(csync_out) && !$past(csync_out, 2)
            |-> !bus_request_n;
    endproperty
    a_req_busy: assert property (p_req_busy) else $error("no request outside sync");

    property p_mux_cpu;
        $past(reset_n) && $past(bus_grant_n) && $past(bus_grant_n, 2) |-> ram_addr == $past(cpu_ram_addr);
    endproperty
    a_mux_cpu: assert property (p_mux_cpu) else $error("ram address not from processor");

    property p_csync;
        csync_out == (hsync_out ^ vsync_out);
    endproperty
    a_csync: assert property (p_csync) else $error("composite sync mismatch");

    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");

    property p_blank_all;
        blank_cnt_r == 10'h3FF |-> !video_out;
    endproperty
    a_blank_all: assert property (p_blank_all) else $error("video lit while blanked");

    property p_hsync_dark;
        hsync_out |-> !video_out;
    endproperty
    a_hsync_dark: assert property (p_hsync_dark) else $error("video lit in line blank");

    property p_vsync_dark;
        vsync_out |-> !video_out;
    endproperty
    a_vsync_dark: assert property (p_vsync_dark) else $error("video lit in vertical sync");
endmodule // cvap_char_video_chk

bind cvap_char_video cvap_char_video_chk chk_u (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus_request_n(bus_request_n), .bus_grant_n(bus_grant_n), .cpu_ram_addr(cpu_ram_addr),
    .ram_addr(ram_addr), .video_out(video_out), .hsync_out(hsync_out), .vsync_out(vsync_out),
    .csync_out(csync_out));

/* test/cvap_cpu_ram_model.sv */
`timescale 1ns/1ps
module cvap_cpu_ram_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Bus arbitration
    input wire logic bus_request_n,
    output logic bus_grant_n,
    // Display word and grant delay
    input wire logic [7:0] word,
    input wire logic [3:0] lag,
    output logic [7:0] ram_rdata
);
    // ----------------------------------------
    // Processor side of the shared RAM
    // ----------------------------------------
    logic [3:0] wait_r;

    // Grants after lag cycles, lets go as soon as the request drops
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_r <= 4'h0;
            bus_grant_n <= 1'b1;
        end else if (bus_request_n) begin
            wait_r <= 4'h0;
            bus_grant_n <= 1'b1;
        end else begin
            if (wait_r != 4'hF) begin
                wait_r <= wait_r + 4'h1;
            end
            bus_grant_n <= (wait_r < lag);
        end
    end

    // Processor owns the data bus until granted, so display reads see junk
    assign ram_rdata = bus_grant_n ? ~word : word;
endmodule // cvap_cpu_ram_model

/* test/tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic bus_request_n;
    logic bus_grant_n;
    logic [cvap_pkg::RAM_AW-1:0] cpu_ram_addr = '0;
    logic [cvap_pkg::RAM_AW-1:0] ram_addr;
    logic [7:0] ram_rdata;
    logic [7:0] word = 8'h00;
    logic [3:0] lag = 4'h0;
    logic video_out, hsync_out, vsync_out, csync_out, blink_out;
    logic [6:0] code;
    int n_mismatch = 0;
    int checks_done = 0;
    int lit, run, gap, req_lo;

    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cpu_ram_addr <= 12'($urandom);

    cvap_char_video dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_request_n(bus_request_n),
        .bus_grant_n(bus_grant_n), .cpu_ram_addr(cpu_ram_addr), .ram_addr(ram_addr), .ram_rdata(ram_rdata),
        .video_out(video_out), .hsync_out(hsync_out), .vsync_out(vsync_out), .csync_out(csync_out),
        .blink_out(blink_out));
    cvap_cpu_ram_model model_u (.sys_clk(sys_clk), .reset_n(reset_n), .bus_request_n(bus_request_n),
        .bus_grant_n(bus_grant_n), .word(word), .lag(lag), .ram_rdata(ram_rdata));

    // ----------------------------------------
    // Tasks and expectations
    // ----------------------------------------
    function automatic int cyc(input int dots);
        return int'(dots * cvap_pkg::SYS_CLK_HZ / cvap_pkg::DOT_CLK_HZ);
    endfunction

    // Dot-clock phase jitter allows one cycle early or two cycles late
    function automatic logic near(input int v, input int dots);
        return v >= cyc(dots) - 1 && v <= cyc(dots) + 2;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        `CHK("reg_rdata", e, reg_rdata & m)
    endtask

    task automatic glyph(input logic [6:0] c, input logic [7:0] p);
        wr(cvap_pkg::REG_GLYPH_ADDR, {1'b0, c});
        repeat (16) wr(cvap_pkg::REG_GLYPH_DATA, p);
    endtask

    task automatic watch(input int n);
        int since;
        int cur;
        // Lets words already in the character pipeline drain
        repeat (500) @(posedge sys_clk);
        lit = 0;
        run = 0;
        gap = 100000;
        req_lo = 0;
        since = 100000;
        cur = 0;
        repeat (n) begin
            @(negedge sys_clk);
            since++;
            if (video_out === 1'b1) begin
                if (cur == 0 && since < gap) gap = since;
                if (cur == 0) since = 0;
                cur++;
                lit++;
                if (cur > run) run = cur;
            end else begin
                cur = 0;
            end
            if (bus_request_n === 1'b0) req_lo++;
        end
        @(posedge sys_clk);
    endtask

    task automatic done(input string nm);
        $display("test %s done", nm);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        #320000;
        n_mismatch++;
        summarize();
    end

    initial begin
        void'($urandom(32'hCF40));
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(cvap_pkg::REG_STATUS, 8'h00, 8'h3F);
        rd(cvap_pkg::REG_VIDEO_CTRL, 8'h00, 8'hFF);
        wr(cvap_pkg::REG_CURSOR + 8'h04, 8'($urandom % 24));
        rd(cvap_pkg::REG_CURSOR + 8'h04, 8'h00, 8'hFF);
        repeat (4) rd(8'(8'h18 + $urandom % 200), 8'h00, 8'hFF);
        done("registers");
        code = 7'($urandom);
        for (int c = 0; c < 128; c++) glyph(7'(c), (7'(c) == code) ? 8'h80 : 8'h00);
        word <= {1'b0, code};
        watch(5000);
        `CHK("lit", 1'b1, lit > 0)
        `CHK("run", 1'b1, near(run, 2))
        word <= {1'b0, code ^ 7'(1 << ($urandom % 7))};
        lag <= 4'($urandom % 8);
        watch(5000);
        `CHK("lit", 0, lit)
        done("glyph address");
        glyph(code, 8'h01);
        word <= {1'b0, code};
        rd(cvap_pkg::REG_GLYPH_ADDR, {1'b0, 7'(code + 7'h01)}, 8'hFF);
        watch(5000);
        `CHK("run", 1'b1, near(run, 1))
        `CHK("gap", 1'b1, near(gap, 9))
        done("cell width");
        glyph(code, 8'h00);
        word <= {1'b1, code};
        lag <= 4'($urandom % 16);
        wr(cvap_pkg::REG_VIDEO_CTRL, 8'h86);
        watch(20000);
        `CHK("run", 1'b1, run > 1000)
        `CHK("lit", 1'b1, lit < 20000)
        `CHK("req", 1'b1, req_lo > 0 && req_lo < 20000)
        wr(cvap_pkg::REG_VIDEO_CTRL, 8'h90);
        watch(5000);
        `CHK("lit", 0, lit)
        done("reverse");
        wr(cvap_pkg::REG_VIDEO_CTRL, 8'h8C);
        watch(5000);
        `CHK("lit", 0, lit)
        wr(cvap_pkg::REG_VIDEO_CTRL, 8'h04);
        watch(5000);
        `CHK("req", 0, req_lo)
        `CHK("blink", 1'b0, blink_out)
        done("blank and hold");
        summarize();
    end
endmodule // tb
